/* bench/slpg_assertions.sv */
// slpg_assertions.sv: port checker for slpg_top, bound below.
// assumes: control writes are seen on the bus, byte lane 0 enabled.
`timescale 1ns/100ps
module slpg_chk #(
	parameter [23:0] TICK_DIV = 24'h030D40
) (
	// clock and reset
	input wire ref_clk,
	input wire srst,
	// register bus
	input wire [3:0] avs_address,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	input wire avs_waitrequest,
	// pins
	input wire [6:0] addr_sw,
	input wire [6:0] node_addr,
	input wire ctrl_led,
	input wire net_led
);
	// ==========================================
	// shadow of control bits and lamp run lengths
	reg [7:0] ctl; // control bits, strobe dropped
	reg [1:0] age; // edges since reset
	reg [1:0] tog; // status toggles since write
	reg [31:0] run; // status run length
	reg [31:0] lo_run; // last dark run
	reg [31:0] nrun; // network run length
	reg pc; // last status level
	reg pn; // last network level
	wire [31:0] d = avs_writedata; // short alias
	wire wr = avs_write && !avs_waitrequest && avs_address[3:2] == 2'h0
		&& avs_byteenable[0];
	wire rst_evt = wr && ctl[0] && d[0]
		&& (d[5] || (ctl[4] && !d[4]) || (ctl[3] && !d[3]));
	wire [31:0] half = TICK_DIV * (ctl[4] ? 32'h12C
		: (ctl[2] | ctl[3]) ? 32'h1F4 : 32'h3E8);
	wire [31:0] pmax = TICK_DIV * 32'hFA + 32'h4; // pulse plus lag
	// track writes, toggles and run lengths
	always @(posedge ref_clk) begin
		pc <= ctrl_led;
		pn <= net_led;
		run <= (ctrl_led != pc) ? 32'h1 : run + 32'h1;
		nrun <= (net_led != pn || wr) ? 32'h1 : nrun + 32'h1;
		if (ctrl_led && !pc)
			lo_run <= run;
		if (srst) begin
			ctl <= 8'h00;
			age <= 2'h0;
			tog <= 2'h0;
		end else begin
			if (age != 2'h3)
				age <= age + 2'h1;
			if (wr)
				ctl <= d[7:0] & 8'hDF;
			if (wr)
				tog <= 2'h0;
			else if (ctrl_led != pc && tog != 2'h3)
				tog <= tog + 2'h1;
		end
	end
	// ==========================================
	// properties
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	node_follow_a: assert property (age == 2'h3 |->
		node_addr == $past(addr_sw, 3)) else $error("node address stale");
	off_dark_a: assert property ((!ctl[0]) [*4] |->
		!ctrl_led && !net_led) else $error("lamp lit without power");
	first_dark_a: assert property ($rose(ctl[0]) |=>
		(!ctrl_led) [*8]) else $error("status lit in first second");
	restart_lit_a: assert property (rst_evt |->
		##[1:4] ctrl_led [*8]) else $error("status not lit on restart");
	blink_half_a: assert property ($fell(ctrl_led) && tog == 2'h3 |->
		run == half && lo_run == half) else $error("blink half wrong");
	net_steady_a: assert property ((ctl[0] && !ctl[1] && !ctl[4]) [*4]
		|-> net_led) else $error("network lamp not steady");
	// judged from the second edge of a run: at the first, nrun still
	// holds the length of the run before it
	app_pulse_a: assert property (ctl[0] && ctl[1] && !ctl[4] && pn
		&& net_led |-> nrun <= pmax) else $error("network lit too long");
	flash_gap_a: assert property (ctl[0] && ctl[4] && !pn
		&& !net_led |-> nrun <= pmax) else $error("network dark too long");
	cover property (rst_evt);
	cover property ($fell(ctrl_led) && tog == 2'h3 && ctl[4]);
	cover property ($rose(net_led) && ctl[1] && !ctl[4]);
endmodule // slpg_chk

bind slpg_top slpg_chk #(.TICK_DIV(TICK_DIV)) slpg_chk_inst (
	.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
	.avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
	.addr_sw(addr_sw), .node_addr(node_addr), .ctrl_led(ctrl_led),
	.net_led(net_led));

/* bench/slpg_leds.sv */
// slpg_leds.sv: the two indicator lamps, measuring what they show.
// assumes: lamp drives sampled on the system clock.
`timescale 1ns/100ps
module slpg_leds (
	// clock
	input wire ref_clk,
	// lamp drives
	input wire ctrl_led,
	input wire net_led,
	// measurements
	output reg [31:0] hi_len,
	output reg [31:0] falls,
	output reg [31:0] net_rise,
	output reg [31:0] net_fall
);
	reg [31:0] run; // cycles at present level
	reg pc; // last status level
	reg pn; // last network level
	// ==========================================
	// lamp edge counting
	initial begin
		hi_len = 32'h0;
		falls = 32'h0;
		net_rise = 32'h0;
		net_fall = 32'h0;
		run = 32'h0;
		pc = 1'b0;
		pn = 1'b0;
	end
	// lit run length and edge counts
	always @(posedge ref_clk) begin
		pc <= ctrl_led;
		pn <= net_led;
		run <= (ctrl_led != pc) ? 32'h1 : run + 32'h1;
		if (pc && !ctrl_led) begin
			hi_len <= run;
			falls <= falls + 32'h1;
		end
		if (net_led && !pn)
			net_rise <= net_rise + 32'h1;
		if (pn && !net_led)
			net_fall <= net_fall + 32'h1;
	end
endmodule // slpg_leds

/* bench/test_status_led_pattern_gen.sv */
// test_status_led_pattern_gen.sv: self-checking bench for slpg_top.
// assumes: tick cut to 4 cycles, so one second is 4000 cycles.
`timescale 1ns/100ps
module test_status_led_pattern_gen;
	localparam [23:0] TD = 24'h000004; // cycles per tick
	// ==========================================
	// signals
	reg ref_clk, srst, avs_read, avs_write; // clock, reset, strobes
	reg [3:0] avs_address, avs_byteenable; // address, lanes
	reg [31:0] avs_writedata, q; // write data, read value
	reg [6:0] addr_sw; // switch pins
	wire [31:0] avs_readdata, hi_len, falls, net_rise, net_fall;
	wire avs_waitrequest, ctrl_led, net_led; // design outputs
	wire [6:0] node_addr; // synced switches
	integer bad_count, checks_done, cycles; // counters
	slpg_top #(.TICK_DIV(TD)) slpg_top_inst (.ref_clk(ref_clk),
		.srst(srst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .addr_sw(addr_sw),
		.node_addr(node_addr), .ctrl_led(ctrl_led), .net_led(net_led));
	slpg_leds slpg_leds_inst (.ref_clk(ref_clk), .ctrl_led(ctrl_led),
		.net_led(net_led), .hi_len(hi_len), .falls(falls),
		.net_rise(net_rise), .net_fall(net_fall));
	// ==========================================
	// helpers
	task automatic check(input string nm, input [31:0] seen,
		input [31:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input [31:0] n);
		repeat (n) @(posedge ref_clk);
	endtask
	// one bus access, held until waitrequest is sampled low
	task automatic bus(input w, input [3:0] a, input [31:0] dat);
		avs_address <= a;
		avs_writedata <= dat;
		avs_read <= !w;
		avs_write <= w;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic t_start;
		bus(1'b0, 4'h0, 32'h0);
		check("control", q, 32'h0);
		bus(1'b0, 4'h4, 32'h0);
		check("divisor", q, {8'h00, TD});
		// divisor is writable, top byte not stored; then restored
		bus(1'b1, 4'h4, 32'hFF000008);
		bus(1'b0, 4'h4, 32'h0);
		check("divisor write", q, 32'h8);
		bus(1'b1, 4'h4, {8'h00, TD});
		check("status lamp", ctrl_led, 1'b0);
		check("network lamp", net_led, 1'b0);
		addr_sw <= 7'h00;
		cyc(4);
		bus(1'b0, 4'h8, 32'h0);
		check("zero flag", q[4:0], 5'h00);
		addr_sw <= 7'h55;
		cyc(4);
		bus(1'b0, 4'hC, 32'h0);
		check("node register", q, 32'h55);
		check("node pins", node_addr, 7'h55);
		$display("done start");
	endtask
	task automatic t_power;
		bus(1'b1, 4'h0, 32'h1);
		cyc(32'h384 * TD);
		check("first second", ctrl_led, 1'b0);
		check("network steady", net_led, 1'b1);
		cyc(32'hC8 * TD);
		check("checking lit", ctrl_led, 1'b1);
		bus(1'b0, 4'h8, 32'h0);
		check("checking state", q[4:3], 2'h2);
		check("node flag", q[0], 1'b1);
		check("status lamps", q[2:1], 2'h3);
		cyc(32'h514 * TD);
		check("checking held", ctrl_led, 1'b1);
		$display("done power");
	endtask
	// second full lit run after a mode change
	task automatic t_blink(input [7:0] c, input [31:0] half);
		reg [31:0] f0;
		bus(1'b1, 4'h0, {24'h0, c});
		f0 = falls;
		while (falls - f0 < 32'h2) @(posedge ref_clk);
		check("blink", hi_len, half * TD);
		$display("done blink %0h", c);
	endtask
	// pulses seen in one whole frame
	task automatic t_net(input [7:0] c, input [31:0] n, input dark);
		reg [31:0] r0;
		bus(1'b1, 4'h0, {24'h0, c});
		cyc(8);
		r0 = dark ? net_fall : net_rise;
		cyc(32'h9C4 * TD);
		check("pulses", (dark ? net_fall : net_rise) - r0, n);
		$display("done network %0h", c);
	endtask
	task automatic t_restart;
		bus(1'b1, 4'h0, 32'h3);
		cyc(32'h64 * TD);
		check("restart lit", ctrl_led, 1'b1);
		bus(1'b0, 4'h8, 32'h0);
		check("restart state", q[4:3], 2'h2);
		cyc(32'h514 * TD);
		check("restart held", ctrl_led, 1'b1);
		// software restart strobe from the running state
		cyc(32'h190 * TD);
		bus(1'b0, 4'h8, 32'h0);
		check("running state", q[4:3], 2'h3);
		bus(1'b1, 4'h0, 32'h23);
		cyc(32'h64 * TD);
		check("strobe lit", ctrl_led, 1'b1);
		bus(1'b0, 4'h8, 32'h0);
		check("strobe state", q[4:3], 2'h2);
		bus(1'b0, 4'h0, 32'h0);
		check("strobe cleared", q, 32'h3);
		bus(1'b1, 4'h0, 32'h0);
		cyc(3);
		check("off status", ctrl_led, 1'b0);
		check("off network", net_led, 1'b0);
		$display("done restart");
	endtask
	// ==========================================
	// clock, timeout and main sequence
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 100000) begin
			bad_count = bad_count + 1;
			complete_run;
		end
	end
	initial begin
		{srst, avs_read, avs_write} = 3'h4;
		{avs_address, avs_byteenable} = 8'h0F;
		avs_writedata = 32'h0;
		addr_sw = 7'h7F;
		{bad_count, checks_done, cycles} = 96'h0;
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		t_start;
		t_power;
		t_blink(8'h01, 32'h3E8);
		t_blink(8'h05, 32'h1F4);
		t_blink(8'h0D, 32'h1F4);
		t_blink(8'h1D, 32'h12C);
		t_net(8'h03, 32'h1, 1'b0);
		t_net(8'h43, 32'h2, 1'b0);
		t_net(8'h83, 32'h3, 1'b0);
		t_net(8'h93, 32'h3, 1'b1);
		t_restart;
		complete_run;
	end
endmodule // test_status_led_pattern_gen

/* design/slpg_burst.v */
// slpg_burst.v: 2.5 s frame with one to three evenly spaced pulses
// at its start, for the network indicator.
// assumes: tick is a one-cycle pulse per millisecond.
`timescale 1ns/100ps
`include "slpg_regs.vh"

module slpg_burst (
	// clock and reset
	input wire ref_clk,
	input wire srst,
	// timebase and pulse count
	input wire tick,
	input wire [1:0] pulses,
	output reg active
);

	// ==========================================================
	// slot and position counters
	reg [2:0] slot; // 500 ms slot within frame
	reg [8:0] pos; // ms within slot

	// frame walk: five slots of 500 ms make 2.5 s
	always @(posedge ref_clk) begin
		if (srst) begin
			slot <= 3'h0;
			pos <= 9'h000;
		end else if (tick) begin
			if (pos == `SLPG_PITCH_MS - 9'h001) begin
				pos <= 9'h000;
				// wrap after last slot
				if (slot == `SLPG_FRAME_SLOTS - 3'h1)
					slot <= 3'h0;
				else
					slot <= slot + 3'h1;
			end else begin
				pos <= pos + 9'h001;
			end
		end
	end

	// pulse in first half of each of the first n slots
	always @(posedge ref_clk) begin
		if (srst)
			active <= 1'b0;
		else
			active <= (slot < {1'b0, pulses}) && (pos < `SLPG_PULSE_MS);
	end

endmodule // slpg_burst

/* design/slpg_tick.v */
// slpg_tick.v: programmable prescaler giving a one-cycle tick.
// assumes: div comes from a register on the same clock.
`timescale 1ns/100ps

module slpg_tick (
	// clock and reset
	input wire ref_clk,
	input wire srst,
	// divisor and tick
	input wire [23:0] div,
	output reg tick
);

	// ==========================================================
	// cycle counter
	reg [23:0] cnt; // cycles since last tick
	wire [23:0] last; // terminal count
	// a divisor of zero behaves as one
	assign last = (div == 24'h000000) ? 24'h000000 : div - 24'h000001;

	// count up, tick on terminal count
	always @(posedge ref_clk) begin
		if (srst) begin
			cnt <= 24'h000000;
			tick <= 1'b0;
		end else if (cnt >= last) begin
			cnt <= 24'h000000;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 24'h000001;
			tick <= 1'b0;
		end
	end

endmodule // slpg_tick

/* design/slpg_top.v */
// slpg_top.v: blink pattern generator for the controller status and
// network status indicators, with an Avalon-MM register slave.
// assumes: one 200 MHz clock, synchronous reset at power-up, software
// writes the condition bits, address switches are asynchronous pins.
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`include "slpg_regs.vh"

module slpg_top #(
	parameter [23:0] TICK_DIV = `SLPG_TICK_DIV
) (
	// clock and reset
	input wire ref_clk,
	input wire srst,
	// avalon-mm slave
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	// address switches
	input wire [6:0] addr_sw,
	output reg [6:0] node_addr,
	// indicators
	output reg ctrl_led,
	output reg net_led
);

	// ==========================================================
	// controller states
	localparam ST_DARK = 2'h0; // unpowered processor
	localparam ST_WAIT = 2'h1; // first second after power
	localparam ST_CHECK = 2'h2; // checksum being verified
	localparam ST_RUN = 2'h3; // blinking patterns

	// ==========================================================
	// word select within the register map
	function slpg_hit;
		input [3:0] addr;
		input [3:0] off;
		begin
			slpg_hit = (addr[3:2] == off[3:2]);
		end
	endfunction

	// ==========================================================
	// bus slave
	reg ack; // one wait state then answer
	reg [7:0] ctrl; // condition bits from software
	reg [23:0] tick_div; // prescaler divisor
	wire acc; // request present
	wire wr_go; // write takes effect
	reg [31:0] next_rdata; // read mux
	integer i;

	assign acc = avs_read | avs_write;
	assign avs_waitrequest = acc & ~ack;
	assign wr_go = avs_write & ack;

	// answer in the second cycle of each request
	always @(posedge ref_clk) begin
		if (srst)
			ack <= 1'b0;
		else
			ack <= acc & ~ack;
	end

	// ==========================================================
	// address switch synchroniser
	reg [6:0] sw_s1; // first stage, read only by sw_s2
	reg [6:0] sw_s2; // second stage

	// two flops before any use
	always @(posedge ref_clk) begin
		if (srst) begin
			sw_s1 <= 7'h00;
			sw_s2 <= 7'h00;
			node_addr <= 7'h00;
		end else begin
			sw_s1 <= addr_sw;
			sw_s2 <= sw_s1;
			node_addr <= sw_s2;
		end
	end

	// ==========================================================
	// control and divisor registers
	wire ctrl_wr; // write hits control byte
	wire restart_req; // software restart strobe

	assign ctrl_wr = wr_go & slpg_hit(avs_address, `SLPG_OFF_CTRL) &
		avs_byteenable[0];
	assign restart_req = ctrl_wr & avs_writedata[`SLPG_CTRL_RESTART];

	// restart bit is a strobe and is never stored
	always @(posedge ref_clk) begin
		if (srst) begin
			ctrl <= `SLPG_CTRL_RESET;
			tick_div <= TICK_DIV;
		end else begin
			if (ctrl_wr) begin
				ctrl <= avs_writedata[7:0] &
					~(8'h01 << `SLPG_CTRL_RESTART);
			end
			// divisor takes bytes 0 to 2
			if (wr_go & slpg_hit(avs_address, `SLPG_OFF_TICK)) begin
				for (i = 0; i < 3; i = i + 1) begin
					if (avs_byteenable[i])
						tick_div[i*8 +: 8] <= avs_writedata[i*8 +: 8];
				end
			end
		end
	end

	// named condition bits
	wire proc_ok; // processor powered, loader usable
	wire app_run; // application running
	wire alarm; // alarm active
	wire dnld; // configuration download in progress
	wire flash; // reflash mode
	wire [1:0] comm; // 0 none, 1 present, 2/3 transfer

	assign proc_ok = ctrl[`SLPG_CTRL_PROC_OK];
	assign app_run = ctrl[`SLPG_CTRL_APP];
	assign alarm = ctrl[`SLPG_CTRL_ALARM];
	assign dnld = ctrl[`SLPG_CTRL_DNLD];
	assign flash = ctrl[`SLPG_CTRL_FLASH];
	assign comm = ctrl[`SLPG_CTRL_COMM_HI:`SLPG_CTRL_COMM_LO];

	// ==========================================================
	// timebase
	wire tick; // one millisecond pulse

	slpg_tick u_tick (
		.ref_clk(ref_clk),
		.srst(srst),
		.div(tick_div),
		.tick(tick)
	);

	// ==========================================================
	// restart detection
	reg flash_d; // reflash bit one cycle ago
	reg dnld_d; // download bit one cycle ago
	wire restart; // any cause of restart

	// end of reflash or download restarts the checksum
	always @(posedge ref_clk) begin
		if (srst) begin
			flash_d <= 1'b0;
			dnld_d <= 1'b0;
		end else begin
			flash_d <= flash;
			dnld_d <= dnld;
		end
	end

	assign restart = restart_req | (flash_d & ~flash) | (dnld_d & ~dnld);

	// ==========================================================
	// controller state machine
	reg [1:0] state; // current state
	reg [1:0] next_state;
	reg [10:0] timer; // ms spent in state
	reg [10:0] next_timer;

	// state transitions
	always @* begin
		next_state = state;
		next_timer = timer;
		if (tick)
			next_timer = timer + 11'h001;
		case (state)
			ST_DARK: begin
				if (proc_ok) begin
					next_state = ST_WAIT;
					next_timer = 11'h000;
				end
			end
			ST_WAIT: begin
				if (tick && timer == `SLPG_PWRUP_MS - 11'h001) begin
					next_state = ST_CHECK;
					next_timer = 11'h000;
				end
			end
			ST_CHECK: begin
				if (tick && timer == `SLPG_CHECK_MS - 11'h001) begin
					next_state = ST_RUN;
					next_timer = 11'h000;
				end
			end
			ST_RUN: begin
				next_timer = 11'h000;
			end
			default: begin
				next_state = ST_DARK;
				next_timer = 11'h000;
			end
		endcase
		// restart outside the dark state forces a new checksum pass
		if (restart && state != ST_DARK) begin
			next_state = ST_CHECK;
			next_timer = 11'h000;
		end
		// loss of processor power overrides all
		if (!proc_ok) begin
			next_state = ST_DARK;
			next_timer = 11'h000;
		end
	end

	// state registers
	always @(posedge ref_clk) begin
		if (srst) begin
			state <= ST_DARK;
			timer <= 11'h000;
		end else begin
			state <= next_state;
			timer <= next_timer;
		end
	end

	// ==========================================================
	// blink half period by priority
	reg [10:0] half; // current half period in ms
	always @* begin
		if (flash)
			half = `SLPG_FLASH_MS;
		else if (alarm | dnld)
			half = `SLPG_ALARM_MS;
		else
			half = `SLPG_NORM_MS;
	end

	// ==========================================================
	// blink generator
	reg [10:0] phase; // ms in current half
	reg [10:0] half_d; // half period last cycle
	reg blink; // lit half of the pattern

	// restart lit whenever the pattern changes or run begins
	always @(posedge ref_clk) begin
		if (srst) begin
			phase <= 11'h000;
			half_d <= `SLPG_NORM_MS;
			blink <= 1'b1;
		end else begin
			half_d <= half;
			if (state != ST_RUN || half != half_d) begin
				phase <= 11'h000;
				blink <= 1'b1;
			end else if (tick) begin
				if (phase >= half - 11'h001) begin
					phase <= 11'h000;
					blink <= ~blink;
				end else begin
					phase <= phase + 11'h001;
				end
			end
		end
	end

	// ==========================================================
	// network indicator pulses
	reg [1:0] pulses; // pulses per frame
	wire burst; // pulse currently active

	// one, two or three pulses per communication state
	always @* begin
		case (comm)
			2'h0: pulses = 2'h1;
			2'h1: pulses = 2'h2;
			default: pulses = 2'h3;
		endcase
	end

	slpg_burst u_burst (
		.ref_clk(ref_clk),
		.srst(srst),
		.tick(tick),
		.pulses(pulses),
		.active(burst)
	);

	// ==========================================================
	// indicator outputs
	always @(posedge ref_clk) begin
		if (srst) begin
			ctrl_led <= 1'b0;
			net_led <= 1'b0;
		end else begin
			// controller status indicator
			case (state)
				ST_CHECK: ctrl_led <= 1'b1;
				ST_RUN: ctrl_led <= blink;
				default: ctrl_led <= 1'b0;
			endcase
			// network status indicator
			if (!proc_ok)
				net_led <= 1'b0;
			else if (flash)
				net_led <= ~burst;
			else if (app_run)
				net_led <= burst;
			else
				net_led <= 1'b1;
		end
	end

	// ==========================================================
	// read mux and read data register
	always @* begin
		next_rdata = 32'h00000000;
		if (slpg_hit(avs_address, `SLPG_OFF_CTRL))
			next_rdata[7:0] = ctrl;
		else if (slpg_hit(avs_address, `SLPG_OFF_TICK))
			next_rdata[23:0] = tick_div;
		else if (slpg_hit(avs_address, `SLPG_OFF_STAT)) begin
			next_rdata[`SLPG_STAT_NODE_OK] = (node_addr != 7'h00);
			next_rdata[`SLPG_STAT_NET_LED] = net_led;
			next_rdata[`SLPG_STAT_CTRL_LED] = ctrl_led;
			next_rdata[`SLPG_STAT_STATE_HI:`SLPG_STAT_STATE_LO] = state;
		end else
			next_rdata[6:0] = node_addr;
	end

	// data captured in the waited cycle, stands while answered
	always @(posedge ref_clk) begin
		if (srst)
			avs_readdata <= 32'h00000000;
		else if (avs_read & ~ack)
			avs_readdata <= next_rdata;
	end

endmodule // slpg_top

/* pkg/slpg_regs.vh */
// slpg_regs.vh: offsets, field positions, reset values and timing
// constants of the status indicator pattern generator.
// assumes: included by bare name from every design file that needs it.
`ifndef SLPG_REGS_VH
`define SLPG_REGS_VH

// ==========================================================
// register byte offsets (one aligned 32-bit word each)
`define SLPG_OFF_CTRL 4'h0
`define SLPG_OFF_TICK 4'h4
`define SLPG_OFF_STAT 4'h8
`define SLPG_OFF_NODE 4'hC

// ==========================================================
// control register fields
`define SLPG_CTRL_PROC_OK 0
`define SLPG_CTRL_APP 1
`define SLPG_CTRL_ALARM 2
`define SLPG_CTRL_DNLD 3
`define SLPG_CTRL_FLASH 4
`define SLPG_CTRL_RESTART 5
`define SLPG_CTRL_COMM_LO 6
`define SLPG_CTRL_COMM_HI 7
`define SLPG_CTRL_RESET 8'h00

// ==========================================================
// status register fields
`define SLPG_STAT_NODE_OK 0
`define SLPG_STAT_NET_LED 1
`define SLPG_STAT_CTRL_LED 2
`define SLPG_STAT_STATE_LO 3
`define SLPG_STAT_STATE_HI 4

// ==========================================================
// timebase: one tick per millisecond
`define SLPG_CLK_MHZ 200
`define SLPG_TICK_US 1000
// 200 MHz times 1000 us, sized to the 24-bit divisor register
`define SLPG_TICK_DIV 24'h030D40

// ==========================================================
// times in milliseconds (ticks) and the frame slot count
`define SLPG_PWRUP_MS 11'h3E8
`define SLPG_CHECK_MS 11'h5DC
`define SLPG_NORM_MS 11'h3E8
`define SLPG_ALARM_MS 11'h1F4
`define SLPG_FLASH_MS 11'h12C
`define SLPG_FRAME_SLOTS 3'h5
`define SLPG_PITCH_MS 9'h1F4
`define SLPG_PULSE_MS 9'h0FA

`endif
